// >>> design/ckrc_top.sv
// Clock source selection, safeguard filter, dividers and reset sequencing.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module ckrc_top #(
  parameter bit SAFEGUARD_OPT    = 1'b1,
  parameter bit RESISTOR_OSC_OPT = 1'b0
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write channels
  input  wire logic [ckrc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ckrc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Oscillators
  input  wire logic                       osc_input_pin,
  output logic                            main_osc_run_o,
  output logic                            aux_low_freq_osc_run_o,
  output logic                            resistor_osc_option_o,
  // Reset sources
  input  wire logic                       reset_pin_n,
  input  wire logic                       por_n,
  input  wire logic                       wdg_reset_req,
  // Core side
  input  wire logic                       cpu_stop_req,
  input  wire logic                       instr_start,
  input  wire logic [1:0]                 instr_len,
  output logic                            internal_clock_tick_o,
  output logic                            timer_tick_o,
  output logic                            machine_cycle_tick_o,
  output logic                            instr_done_o,
  output logic                            core_reset_n_o,
  output logic                            io_pullup_force_o
);
  import ckrc_pkg::*;

  typedef struct packed {
    logic             main_prev;
    logic [CNT_W-1:0] miss_cnt;
    logic [CNT_W-1:0] aux_cnt;
    logic [CNT_W-1:0] gap_cnt;
    logic [2:0]       good_cnt;
    logic             sel_aux;
    logic             aux_run;
    logic             osc_run;
    logic             int_tick;
    logic             resistor_opt;
    ckrc_rst_e        rst_st;
    logic [10:0]      dly_cnt;
    logic             core_rst_n;
    logic             io_pullup;
    logic             main_osc_off;
    logic [2:0]       mc_left;
    logic             instr_done;
    logic             aw_got;
    logic             w_got;
    logic [11:0]      awaddr;
    logic [7:0]       wdata_lo;
    logic             wstrb0;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } ckrc_state_s;

  ckrc_state_s s_ff;
  ckrc_state_s nxt_s;

  ckrc_div_if timer_div_bus ();
  ckrc_div_if core_div_bus ();

  // Word-aligned decode shared by the write and read paths.
  function automatic ckrc_sel_e reg_sel(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'b00};
    if (word == OSC_CTRL_ADDR) begin
      reg_sel = CKRC_SEL_OSC;
    end else if (word == STATUS_ADDR) begin
      reg_sel = CKRC_SEL_STAT;
    end else begin
      reg_sel = CKRC_SEL_NONE;
    end
  endfunction

  function automatic logic [2:0] instr_cycles(input logic [1:0] code);
    case (code)
      LEN_CODE_2: instr_cycles = LEN_CYC_2;
      LEN_CODE_4: instr_cycles = LEN_CYC_4;
      default:    instr_cycles = LEN_CYC_5;
    endcase
  endfunction

  logic main_edge;
  logic main_missing;
  logic gap_ok;
  logic main_tick;
  logic aux_en;
  logic aux_tick;
  logic tick;
  logic in_reset;
  logic rst_req;
  logic mc_tick;
  logic [31:0] rd_word;

  always_comb begin
    nxt_s        = s_ff;
    aux_tick     = 1'b0;
    rd_word      = 32'h0000_0000;
    in_reset     = (s_ff.rst_st != CKRC_RUN);
    mc_tick      = core_div_bus.tick_out;
    main_edge    = osc_input_pin & ~s_ff.main_prev;
    nxt_s.main_prev = osc_input_pin;

    // Off bit acts only when the safeguard is built in; any reset turns the oscillator on again.
    nxt_s.osc_run = in_reset | (~cpu_stop_req & ~(SAFEGUARD_OPT & s_ff.main_osc_off));

    main_missing = (s_ff.miss_cnt >= CNT_W'(MISS_CYC));
    if (main_edge) begin
      nxt_s.miss_cnt = '0;
    end else if (!main_missing) begin
      nxt_s.miss_cnt = s_ff.miss_cnt + 6'h01;
    end

    // An edge closer than the safeguard period to the last tick is a spike and is dropped.
    gap_ok    = (s_ff.gap_cnt >= CNT_W'(SG_GAP_M1));
    main_tick = main_edge & (~SAFEGUARD_OPT | gap_ok);

    // The auxiliary counter restarts from zero, so its first tick comes one full period later.
    aux_en = SAFEGUARD_OPT & s_ff.sel_aux & (~cpu_stop_req | in_reset);
    if (aux_en) begin
      if (s_ff.aux_cnt == CNT_W'(AUX_CYC - 1)) begin
        nxt_s.aux_cnt = '0;
        aux_tick      = 1'b1;
      end else begin
        nxt_s.aux_cnt = s_ff.aux_cnt + 6'h01;
      end
    end else begin
      nxt_s.aux_cnt = '0;
    end
    nxt_s.aux_run = aux_en;

    // Source selection: leave main on a missing edge, return after a run of clean edges.
    if (!s_ff.sel_aux) begin
      if (SAFEGUARD_OPT && main_missing) begin
        nxt_s.sel_aux  = 1'b1;
        nxt_s.good_cnt = 3'h0;
      end
    end else if (main_missing || !s_ff.osc_run) begin
      nxt_s.good_cnt = 3'h0;
    end else if (main_tick) begin
      if (s_ff.good_cnt == 3'(MAIN_GOOD_EDGES - 1)) begin
        nxt_s.sel_aux  = 1'b0;
        nxt_s.good_cnt = 3'h0;
      end else begin
        nxt_s.good_cnt = s_ff.good_cnt + 3'h1;
      end
    end

    // Ticks of the two sources never mix, and the gap filter spaces the first main tick after a return from the auxiliary source.
    tick           = s_ff.sel_aux ? aux_tick : main_tick;
    nxt_s.int_tick = tick;
    if (tick) begin
      nxt_s.gap_cnt = '0;
    end else if (s_ff.gap_cnt != CNT_MAX) begin
      nxt_s.gap_cnt = s_ff.gap_cnt + 6'h01;
    end

    // Any asserted sample of a source starts a fresh hold, so a short pulse is never lost.
    rst_req = ~reset_pin_n | ~por_n | wdg_reset_req;
    case (s_ff.rst_st)
      CKRC_RST_HOLD: begin
        nxt_s.dly_cnt = 11'h000;
        if (!rst_req) begin
          nxt_s.rst_st = CKRC_RST_DELAY;
        end
      end
      CKRC_RST_DELAY: begin
        if (rst_req) begin
          nxt_s.rst_st = CKRC_RST_HOLD;
        end else if (s_ff.int_tick) begin
          if (s_ff.dly_cnt == 11'(RST_DELAY_TICKS - 1)) begin
            nxt_s.rst_st = CKRC_RUN;
          end else begin
            nxt_s.dly_cnt = s_ff.dly_cnt + 11'h001;
          end
        end
      end
      CKRC_RUN: begin
        if (rst_req) begin
          nxt_s.rst_st = CKRC_RST_HOLD;
        end
      end
      default: begin
        nxt_s.rst_st = CKRC_RST_HOLD;
      end
    endcase
    nxt_s.core_rst_n = (nxt_s.rst_st == CKRC_RUN);
    nxt_s.io_pullup  = ~nxt_s.core_rst_n;

    // Instruction timing in machine cycles; nothing executes while in reset.
    nxt_s.instr_done = 1'b0;
    if (s_ff.mc_left != 3'h0 && mc_tick) begin
      nxt_s.mc_left = s_ff.mc_left - 3'h1;
      if (s_ff.mc_left == 3'h1) begin
        nxt_s.instr_done = 1'b1;
      end
    end
    if (instr_start && !in_reset && nxt_s.mc_left == 3'h0) begin
      nxt_s.mc_left = instr_cycles(instr_len);
    end
    if (in_reset) begin
      nxt_s.mc_left = 3'h0;
    end

    // Write path: address and data are taken in either order, the response follows both.
    if (s_axi_awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_ff.wready) begin
      nxt_s.w_got    = 1'b1;
      nxt_s.wdata_lo = s_axi_wdata[7:0];
      nxt_s.wstrb0   = s_axi_wstrb[0];
    end
    if (s_ff.bvalid && s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = RESP_OKAY;
      case (reg_sel(s_ff.awaddr))
        CKRC_SEL_OSC: begin
          if (s_ff.wstrb0) begin
            nxt_s.main_osc_off = s_ff.wdata_lo[OFF_BIT];
          end
        end
        CKRC_SEL_STAT: nxt_s.bresp = RESP_OKAY;
        default: begin
          nxt_s.bresp = RESP_DECERR;
        end
      endcase
    end
    // A device reset forces the oscillator back on regardless of a write in flight.
    if (in_reset) begin
      nxt_s.main_osc_off = 1'b0;
    end
    nxt_s.awready = ~nxt_s.aw_got & ~nxt_s.bvalid;
    nxt_s.wready  = ~nxt_s.w_got & ~nxt_s.bvalid;

    // Read path: one cycle from address to data.
    if (s_ff.rvalid && s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        CKRC_SEL_OSC: begin
          rd_word[OFF_BIT] = s_ff.main_osc_off;
        end
        CKRC_SEL_STAT: begin
          rd_word[STAT_AUX_BIT] = s_ff.sel_aux;
          rd_word[STAT_RST_BIT] = in_reset;
          rd_word[STAT_RUN_BIT] = s_ff.osc_run;
        end
        default: begin
          nxt_s.rresp = RESP_DECERR;
        end
      endcase
      nxt_s.rdata = rd_word;
    end
    nxt_s.arready = ~nxt_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff              <= '0;
      s_ff.miss_cnt     <= CNT_W'(MISS_CYC);
      s_ff.gap_cnt      <= CNT_MAX;
      s_ff.sel_aux      <= SAFEGUARD_OPT;
      s_ff.osc_run      <= 1'b1;
      s_ff.io_pullup    <= 1'b1;
      s_ff.resistor_opt <= RESISTOR_OSC_OPT;
      s_ff.rst_st       <= CKRC_RST_HOLD;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign timer_div_bus.tick_in = s_ff.int_tick;
  assign core_div_bus.tick_in  = s_ff.int_tick;

  ckrc_div #(.DIV(TIMER_DIV)) u_timer_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (timer_div_bus)
  );

  ckrc_div #(.DIV(CORE_DIV)) u_core_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (core_div_bus)
  );

  assign s_axi_awready          = s_ff.awready;
  assign s_axi_wready           = s_ff.wready;
  assign s_axi_bvalid           = s_ff.bvalid;
  assign s_axi_bresp            = s_ff.bresp;
  assign s_axi_arready          = s_ff.arready;
  assign s_axi_rvalid           = s_ff.rvalid;
  assign s_axi_rdata            = s_ff.rdata;
  assign s_axi_rresp            = s_ff.rresp;
  assign main_osc_run_o         = s_ff.osc_run;
  assign aux_low_freq_osc_run_o = s_ff.aux_run;
  assign resistor_osc_option_o  = s_ff.resistor_opt;
  assign internal_clock_tick_o  = s_ff.int_tick;
  assign timer_tick_o           = timer_div_bus.tick_out;
  assign machine_cycle_tick_o   = core_div_bus.tick_out;
  assign instr_done_o           = s_ff.instr_done;
  assign core_reset_n_o         = s_ff.core_rst_n;
  assign io_pullup_force_o      = s_ff.io_pullup;
endmodule
`default_nettype wire

// >>> design/ckrc_pkg.sv
// Shared constants and types for the clock and reset control block.
package ckrc_pkg;

  // Clock rate and the times the block measures, with their cycle counts.
  localparam int CLK_PERIOD_NS   = 40;
  localparam int MISS_TIMEOUT_NS = 1000;
  localparam int MISS_CYC        = (MISS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUX_PERIOD_NS   = 2000;
  localparam int AUX_CYC         = AUX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SG_MIN_PERIOD_NS = 120;
  localparam int SG_GAP_CYC      = (SG_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SG_GAP_M1       = SG_GAP_CYC - 1;

  // Dividers, reset delay and oscillator start criterion.
  localparam int TIMER_DIV       = 12;
  localparam int CORE_DIV        = 13;
  localparam int RST_DELAY_TICKS = 2048;
  localparam int MAIN_GOOD_EDGES = 4;
  localparam int CNT_W           = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

  // Register map: the printed offset is an index, the byte address is four times it.
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OSC_CTRL_IDX  = 12'h0D1;
  localparam logic [11:0] OSC_CTRL_ADDR = OSC_CTRL_IDX << 2;
  localparam logic [11:0] STATUS_ADDR   = 12'h3F0;
  localparam int          OFF_BIT       = 2;
  localparam int          STAT_AUX_BIT  = 0;
  localparam int          STAT_RST_BIT  = 1;
  localparam int          STAT_RUN_BIT  = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // Instruction length codes and their machine cycle counts.
  localparam logic [1:0] LEN_CODE_2 = 2'h0;
  localparam logic [1:0] LEN_CODE_4 = 2'h1;
  localparam logic [2:0] LEN_CYC_2  = 3'h2;
  localparam logic [2:0] LEN_CYC_4  = 3'h4;
  localparam logic [2:0] LEN_CYC_5  = 3'h5;

  typedef enum logic [1:0] {
    CKRC_RST_HOLD  = 2'b00,
    CKRC_RST_DELAY = 2'b01,
    CKRC_RUN       = 2'b10
  } ckrc_rst_e;

  typedef enum logic [1:0] {
    CKRC_SEL_NONE = 2'b00,
    CKRC_SEL_OSC  = 2'b01,
    CKRC_SEL_STAT = 2'b10
  } ckrc_sel_e;

endpackage

// >>> design/ckrc_div_if.sv
// Tick stream into and out of a clock divider.
`timescale 1ns/100ps
`default_nettype none
interface ckrc_div_if;
  logic tick_in;
  logic tick_out;
  modport src (output tick_in, input tick_out);
  modport div (input tick_in, output tick_out);
endinterface
`default_nettype wire

// >>> design/ckrc_div.sv
// Divides the internal clock tick stream by a fixed ratio.
`timescale 1ns/100ps
`default_nettype none
module ckrc_div #(
  parameter int DIV = 12
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick streams
  ckrc_div_if.div   bus
);
  import ckrc_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } ckrc_div_s;

  ckrc_div_s s_ff;
  ckrc_div_s nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (bus.tick_in) begin
      if (s_ff.cnt == 4'(DIV - 1)) begin
        nxt_s.cnt  = 4'h0;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.tick_out = s_ff.tick;
endmodule
`default_nettype wire

// >>> verif/ckrc_chk.sv
// Port-level assertions for the clock and reset control block.
`timescale 1ns/100ps
`default_nettype none
module ckrc_chk #(
  parameter bit SAFEGUARD_OPT = 1'h1
) (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Block inputs
  input wire logic       osc_input_pin,
  input wire logic       reset_pin_n,
  input wire logic       por_n,
  input wire logic       wdg_reset_req,
  input wire logic       cpu_stop_req,
  input wire logic       instr_start,
  input wire logic [1:0] instr_len,
  // Block outputs
  input wire logic       main_osc_run_o,
  input wire logic       aux_low_freq_osc_run_o,
  input wire logic       internal_clock_tick_o,
  input wire logic       timer_tick_o,
  input wire logic       machine_cycle_tick_o,
  input wire logic       instr_done_o,
  input wire logic       core_reset_n_o,
  input wire logic       io_pullup_force_o
);
  import ckrc_pkg::*;
  logic [4:0]  tmr_n;
  logic [4:0]  cyc_n;
  logic [2:0]  mc_n;
  logic [2:0]  len_n;
  logic [6:0]  gap_n;
  logic [12:0] rel_n;
  logic        tmr_seen;
  logic        cyc_seen;
  logic        pend;
  logic        osc_q;
  logic        src_q;
  wire logic   src_act = !reset_pin_n || !por_n || wdg_reset_req;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A reset may cut a divider period short, so spacing is judged only after a full period.
  always_ff @(posedge aclk) begin
    osc_q <= osc_input_pin;
    src_q <= src_act;
    tmr_n <= timer_tick_o ? 5'h0 : tmr_n + 5'(internal_clock_tick_o);
    cyc_n <= machine_cycle_tick_o ? 5'h0 : cyc_n + 5'(internal_clock_tick_o);
    gap_n <= (!aresetn || (osc_input_pin && !osc_q)) ? 7'h0 : gap_n + 7'(gap_n != 7'h7F);
    rel_n <= (!aresetn || src_act || src_q) ? 13'h0 : rel_n + 13'(internal_clock_tick_o);
    if (machine_cycle_tick_o) mc_n <= mc_n + 3'h1;
    if (!aresetn || !core_reset_n_o) begin
      tmr_seen <= 1'h0;
      cyc_seen <= 1'h0;
      pend <= 1'h0;
    end else begin
      tmr_seen <= tmr_seen || timer_tick_o;
      cyc_seen <= cyc_seen || machine_cycle_tick_o;
      if (instr_done_o) begin
        pend <= 1'h0;
      end else if (instr_start && !pend) begin
        pend <= 1'h1;
        mc_n <= 3'h0;
        len_n <= (instr_len == LEN_CODE_2) ? LEN_CYC_2 : (instr_len == LEN_CODE_4) ? LEN_CYC_4 : LEN_CYC_5;
      end
    end
  end

  timer_div_a: assert property (timer_tick_o && tmr_seen |-> tmr_n + 5'(internal_clock_tick_o) == 5'(TIMER_DIV))
    else $error("timer tick spacing wrong");
  core_div_a: assert property (machine_cycle_tick_o && cyc_seen |-> cyc_n + 5'(internal_clock_tick_o) == 5'(CORE_DIV))
    else $error("machine cycle spacing wrong");
  instr_len_a: assert property (instr_done_o |-> pend && mc_n == len_n)
    else $error("instruction length wrong");
  aux_start_a: assert property (SAFEGUARD_OPT && gap_n == 7'(MISS_CYC + 4) && !cpu_stop_req |-> aux_low_freq_osc_run_o)
    else $error("auxiliary oscillator not started");
  edge_gap_a: assert property (SAFEGUARD_OPT && internal_clock_tick_o |=> !internal_clock_tick_o [*2])
    else $error("internal ticks too close");
  rst_enter_a: assert property (src_act |-> ##[1:3] !core_reset_n_o)
    else $error("reset source not honoured");
  rst_release_a: assert property ($rose(core_reset_n_o) |-> rel_n == 13'(RST_DELAY_TICKS))
    else $error("reset released after wrong tick count");
  io_pullup_a: assert property (io_pullup_force_o == !core_reset_n_o)
    else $error("pull-up force disagrees with reset");
  osc_restart_a: assert property (!core_reset_n_o && !$past(core_reset_n_o) && !$past(core_reset_n_o, 2) |-> main_osc_run_o)
    else $error("main oscillator not restarted in reset");
endmodule

bind ckrc_top ckrc_chk #(.SAFEGUARD_OPT(SAFEGUARD_OPT)) ckrc_chk_inst (.*);
`default_nettype wire

// >>> verif/ckrc_osc_model.sv
// Main oscillator components feeding the oscillator input pin.
`timescale 1ns/100ps
`default_nettype none
module ckrc_osc_model (
  // Clock
  input  wire logic       aclk,
  // Control
  input  wire logic       main_osc_run_o,
  input  wire logic [1:0] osc_mode,
  // Oscillator output
  output logic            osc_input_pin
);
  logic [1:0] phase_ff;

  initial begin
    phase_ff = 2'h0;
    osc_input_pin = 1'h0;
  end

  // A stopped or dead oscillator leaves the pin still, so no stale edge is seen.
  always @(posedge aclk) begin
    phase_ff <= phase_ff + 2'h1;
    if (main_osc_run_o !== 1'h1 || osc_mode == 2'h2) begin
      osc_input_pin <= 1'h0;
    end else if (osc_mode == 2'h1) begin
      osc_input_pin <= ~osc_input_pin;
    end else begin
      osc_input_pin <= phase_ff[1];
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the clock and reset control block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ckrc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_n, por_n, wdg_reset_req;
  logic        osc_input_pin, main_osc_run_o, aux_low_freq_osc_run_o, resistor_osc_option_o, cpu_stop_req;
  logic        internal_clock_tick_o, timer_tick_o, machine_cycle_tick_o, instr_done_o, instr_start;
  logic        core_reset_n_o, io_pullup_force_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, osc_mode, instr_len, r;
  int          mismatches, n_compared, cycles, off_bit, n, i;
  int          len_q[$] = '{2, 4, 5, 5};

  ckrc_top ckrc_top_inst (.*);
  ckrc_osc_model ckrc_osc_model_inst (.*);

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk("rdata", e, d);
    chk("rresp", RESP_OKAY, r);
  endtask

  task automatic wait_tick;
    do @(posedge aclk); while (internal_clock_tick_o !== 1'h1);
  endtask

  // The POR and source tests release just after a tick so no tick straddles the release; the stop test releases without waiting for one.
  task automatic count_release(input string nm);
    logic lo;
    lo = 1'h0;
    n = 0;
    do begin
      @(posedge aclk);
      if (internal_clock_tick_o === 1'h1) n++;
      lo |= core_reset_n_o === 1'h0;
    end while (core_reset_n_o !== 1'h1);
    chk(nm, RST_DELAY_TICKS, n);
    chk("core_reset_seen", 1, lo);
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, wdg_reset_req, cpu_stop_req, instr_start} = '0;
    {instr_len, osc_mode, aresetn, por_n} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready, reset_pin_n} = '1;
    {mismatches, n_compared, cycles, off_bit} = '0;
    seed = 32'h1336;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    wait_tick();
    por_n <= 1'h1;
    count_release("por_release");
    chk("resistor_opt", 0, resistor_osc_option_o);
    rd_chk(OSC_CTRL_ADDR, 0);
    rd_chk(STATUS_ADDR, 32'h4);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      axw(OSC_CTRL_ADDR, d, d[31:28], r);
      chk("bresp", RESP_OKAY, r);
      if (d[28]) off_bit = d[2];
      rd_chk(OSC_CTRL_ADDR, off_bit * 4);
    end
    axw(12'h100, 32'h4, 4'hF, r);
    chk("bresp_unmapped", RESP_DECERR, r);
    axr(12'h100, d, r);
    chk("rresp_unmapped", RESP_DECERR, r);
    chk("rdata_unmapped", 0, d);
    axw(OSC_CTRL_ADDR, 32'hFFFF_FFFF, 4'hF, r);
    off_bit = 1;
    repeat (120) @(posedge aclk);
    chk("main_run", 0, main_osc_run_o);
    chk("aux_run", 1, aux_low_freq_osc_run_o);
    rd_chk(STATUS_ADDR, 32'h1);
    for (i = 0; i < 4; i++) begin
      do @(posedge aclk); while (machine_cycle_tick_o !== 1'h1);
      instr_start <= 1'h1;
      instr_len <= i[1:0];
      @(posedge aclk);
      instr_start <= 1'h0;
      n = 0;
      do begin
        @(posedge aclk);
        if (machine_cycle_tick_o === 1'h1) n++;
      end while (instr_done_o !== 1'h1);
      chk("instr_cycles", len_q[i], n);
    end
    axw(OSC_CTRL_ADDR, 32'h0, 4'hF, r);
    off_bit = 0;
    repeat (120) @(posedge aclk);
    chk("main_run", 1, main_osc_run_o);
    chk("aux_run", 0, aux_low_freq_osc_run_o);
    osc_mode <= 2'h1;
    repeat (200) @(posedge aclk);
    osc_mode <= 2'h2;
    repeat (MISS_CYC + AUX_CYC + 10) @(posedge aclk);
    chk("aux_run", 1, aux_low_freq_osc_run_o);
    osc_mode <= 2'h0;
    repeat (120) @(posedge aclk);
    chk("aux_run", 0, aux_low_freq_osc_run_o);
    cpu_stop_req <= 1'h1;
    repeat (120) @(posedge aclk);
    chk("stop_main_run", 0, main_osc_run_o);
    chk("stop_aux_run", 0, aux_low_freq_osc_run_o);
    reset_pin_n <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("stop_rst_run", 1, main_osc_run_o);
    {reset_pin_n, cpu_stop_req} <= 2'h2;
    count_release("stop_release");
    for (i = 0; i < 3; i++) begin
      axw(OSC_CTRL_ADDR, 32'h4, 4'h1, r);
      wait_tick();
      reset_pin_n <= i != 0;
      wdg_reset_req <= i == 1;
      por_n <= i != 2;
      @(posedge aclk);
      {reset_pin_n, por_n, wdg_reset_req} <= 3'h6;
      count_release("src_release");
      off_bit = 0;
      rd_chk(OSC_CTRL_ADDR, 0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
